// ---- hdl/cdpic_pkg.sv ----
// Types shared by the dual interrupt controller
package cdpic_pkg;
  typedef enum logic [1:0] {ST_READY, ST_W2, ST_W3, ST_W4} cdpic_step_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        wr;
    logic        rd;
  } cdpic_io_t;
  typedef struct packed {
    logic       valid;
    logic [7:0] vector;
  } cdpic_ack_t;
endpackage

// ---- hdl/cdpic_regs.svh ----
// Port addresses, field positions, command codes and reset values of the dual controller
`ifndef CDPIC_REGS_SVH
`define CDPIC_REGS_SVH
`define CDP_MASTER_BASE   16'h0020
`define CDP_MASTER_DATA   16'h0021
`define CDP_SLAVE_BASE    16'h00a0
`define CDP_SLAVE_DATA    16'h00a1
`define CDP_ELCR_MASTER   16'h04d0
`define CDP_ELCR_SLAVE    16'h04d1
`define CDP_INIT_BIT      4
`define CDP_IC4_BIT       0
`define CDP_VEC_HI        7
`define CDP_VEC_LO        3
`define CDP_SEL_HI        4
`define CDP_SEL_LO        3
`define CDP_SEL_EOI_ROTATE_COMMAND      2'h0
`define CDP_SEL_STATUS_SELECT_COMMAND      2'h1
`define CDP_CODE_HI       7
`define CDP_CODE_LO       5
`define CDP_OP_ROT_ACLR   3'h0
`define CDP_OP_NSEOI      3'h1
`define CDP_OP_NOP        3'h2
`define CDP_OP_SEOI       3'h3
`define CDP_OP_ROT_ASET   3'h4
`define CDP_OP_ROT_NSEOI  3'h5
`define CDP_OP_SETPRI     3'h6
`define CDP_OP_ROT_SEOI   3'h7
`define CDP_LVL_HI        2
`define CDP_MODE_SPECIAL_NESTED_MODE     4
`define CDP_MODE_AUTO_END_OF_INTERRUPT     1
`define CDP_RR_BIT        1
`define CDP_RIS_BIT       0
`define CDP_ESMM_BIT      5
`define CDP_SMM_BIT       6
`define CDP_MODE_RESET    8'h01
`define CDP_LOW_PRIO_INIT 3'h7
`define CDP_SLAVE_INIT    3'h7
`define CDP_CASCADE_LINE  3'h2
`define CDP_SPURIOUS_LVL  3'h7
`define CDP_ELCR_MASK_M   8'hf8
`define CDP_ELCR_MASK_S   8'hde
`endif

// ---- hdl/cdpic_top.sv ----
// Cascaded master and slave interrupt controllers behind byte-wide I/O ports
`timescale 1ns/1ps
`include "cdpic_regs.svh"

// ==========================================================
// One eight-input controller
module cdpic_ctrl #(
  parameter logic [7:0] ELCR_MASK = `CDP_ELCR_MASK_M
) (
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_base,
  input  wire logic       wr_data,
  input  wire logic       wr_elcr,
  input  wire logic [7:0] wdata,
  input  wire logic [7:0] irq,
  input  wire logic       ack,
  output logic            int_req,
  output logic            best_found,
  output logic [2:0]      best_lvl,
  output logic [4:0]      vec_base,
  output logic [7:0]      interrupt_mask,
  output logic [7:0]      elcr,
  output logic [7:0]      status
);
  import cdpic_pkg::*;

  cdpic_step_t step_q;
  logic        ic4_q;
  logic [7:0]  imr_q;
  logic [7:0]  irr_q;
  logic [7:0]  isr_q;
  logic [7:0]  prev_q;
  logic [7:0]  elcr_q;
  logic [7:0]  mode_q;
  logic [4:0]  vec_base_q;
  logic [2:0]  slave_addr_q;
  logic [2:0]  prio_low_q;
  logic        read_isr_q;
  logic        smm_q;
  logic        rot_auto_end_of_interrupt_q;

  logic        init_wr;
  logic        eoi_rotate_command_wr;
  logic        status_select_command_wr;
  logic [2:0]  op_code;
  logic [2:0]  op_lvl;
  logic [7:0]  eff_isr;
  logic [3:0]  p_pick;
  logic [3:0]  s_pick;
  logic [7:0]  set_req;
  logic [7:0]  ack_hit;
  logic        granted;

  // ==========================================================
  // Priority resolution
  function automatic logic [3:0] pick(input logic [7:0] bits, input logic [2:0] low);
    logic [2:0] l;
    pick = 4'h0;
    for (int i = 8; i >= 1; i--) begin
      l = low + 3'(i);
      if (bits[l]) begin
        pick = {1'b1, l};
      end
    end
  endfunction

  function automatic logic [2:0] rank(input logic [2:0] lvl, input logic [2:0] low);
    rank = 3'(lvl - low - 3'h1);
  endfunction

  assign init_wr = wr_base && wdata[`CDP_INIT_BIT];
  assign eoi_rotate_command_wr = wr_base && !wdata[`CDP_INIT_BIT] && step_q == ST_READY &&
                   wdata[`CDP_SEL_HI:`CDP_SEL_LO] == `CDP_SEL_EOI_ROTATE_COMMAND;
  assign status_select_command_wr = wr_base && !wdata[`CDP_INIT_BIT] && step_q == ST_READY &&
                   wdata[`CDP_SEL_HI:`CDP_SEL_LO] == `CDP_SEL_STATUS_SELECT_COMMAND;
  assign op_code = wdata[`CDP_CODE_HI:`CDP_CODE_LO];
  assign op_lvl  = wdata[`CDP_LVL_HI:0];
  assign eff_isr = smm_q ? (isr_q & ~imr_q) : isr_q;
  assign p_pick  = pick(irr_q & ~imr_q, prio_low_q);
  assign s_pick  = pick(eff_isr, prio_low_q);
  assign granted = ack && p_pick[3];
  assign ack_hit = granted ? (8'h01 << p_pick[2:0]) : 8'h00;
  // Level lines request while high; edge lines on a rising edge
  assign set_req = ((irq & ~prev_q & ~elcr_q) | (irq & elcr_q)) & ~imr_q;

  // Fully nested, optionally equal level allowed in special nesting
  always_comb begin
    int_req = p_pick[3] && (!s_pick[3] ||
              rank(p_pick[2:0], prio_low_q) < rank(s_pick[2:0], prio_low_q) ||
              (mode_q[`CDP_MODE_SPECIAL_NESTED_MODE] && p_pick[2:0] == s_pick[2:0]));
  end

  assign best_found = p_pick[3];
  assign best_lvl   = p_pick[2:0];
  assign vec_base   = vec_base_q;
  assign interrupt_mask        = imr_q;
  assign elcr       = elcr_q;
  assign status     = read_isr_q ? isr_q : irr_q;

  // ==========================================================
  // Initialisation sequence
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      step_q       <= ST_READY;
      ic4_q        <= 1'b1;
      vec_base_q   <= '0;
      slave_addr_q <= `CDP_SLAVE_INIT;
      mode_q       <= `CDP_MODE_RESET;
    end else if (init_wr) begin
      step_q       <= ST_W2;
      ic4_q        <= wdata[`CDP_IC4_BIT];
      slave_addr_q <= `CDP_SLAVE_INIT;
    end else if (wr_data) begin
      unique case (step_q)
        ST_W2: begin
          vec_base_q <= wdata[`CDP_VEC_HI:`CDP_VEC_LO];
          step_q     <= ST_W3;
        end
        ST_W3: begin
          slave_addr_q <= wdata[2:0];
          step_q       <= ic4_q ? ST_W4 : ST_READY;
        end
        ST_W4: begin
          mode_q <= wdata;
          step_q <= ST_READY;
        end
        ST_READY: begin
          step_q <= ST_READY;
        end
      endcase
    end
  end

  // ==========================================================
  // Mask, status select, special mask and edge/level controls
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      imr_q      <= '0;
      read_isr_q <= 1'b0;
      smm_q      <= 1'b0;
      elcr_q     <= '0;
    end else begin
      if (init_wr) begin
        imr_q      <= '0;
        read_isr_q <= 1'b0;
        smm_q      <= 1'b0;
      end else if (wr_data && step_q == ST_READY) begin
        imr_q <= wdata;
      end else if (status_select_command_wr) begin
        if (wdata[`CDP_RR_BIT]) begin
          read_isr_q <= wdata[`CDP_RIS_BIT];
        end
        if (wdata[`CDP_ESMM_BIT]) begin
          smm_q <= wdata[`CDP_SMM_BIT];
        end
      end
      if (wr_elcr) begin
        elcr_q <= wdata & ELCR_MASK;
      end
    end
  end

  // ==========================================================
  // Request register; a new request wins over the acknowledge clear
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      irr_q  <= '0;
      prev_q <= '0;
    end else begin
      prev_q <= irq;
      irr_q  <= ((irr_q & ~ack_hit) & ~(elcr_q & ~irq)) | set_req;
    end
  end

  // ==========================================================
  // In-service register and rotation
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      isr_q      <= '0;
      prio_low_q <= `CDP_LOW_PRIO_INIT;
      rot_auto_end_of_interrupt_q <= 1'b0;
    end else if (init_wr) begin
      prio_low_q <= `CDP_LOW_PRIO_INIT;
      rot_auto_end_of_interrupt_q <= 1'b0;
    end else begin
      if (eoi_rotate_command_wr) begin
        unique case (op_code)
          `CDP_OP_NSEOI: begin
            if (s_pick[3]) begin
              isr_q[s_pick[2:0]] <= 1'b0;
            end
          end
          `CDP_OP_ROT_NSEOI: begin
            if (s_pick[3]) begin
              isr_q[s_pick[2:0]] <= 1'b0;
              prio_low_q         <= s_pick[2:0];
            end
          end
          `CDP_OP_SEOI: begin
            isr_q[op_lvl] <= 1'b0;
          end
          `CDP_OP_ROT_SEOI: begin
            isr_q[op_lvl] <= 1'b0;
            prio_low_q    <= op_lvl;
          end
          `CDP_OP_SETPRI: begin
            prio_low_q <= op_lvl;
          end
          `CDP_OP_ROT_ASET: begin
            rot_auto_end_of_interrupt_q <= 1'b1;
          end
          `CDP_OP_ROT_ACLR: begin
            rot_auto_end_of_interrupt_q <= 1'b0;
          end
          `CDP_OP_NOP: begin
            rot_auto_end_of_interrupt_q <= rot_auto_end_of_interrupt_q;
          end
        endcase
      end
      if (granted) begin
        if (mode_q[`CDP_MODE_AUTO_END_OF_INTERRUPT]) begin
          if (rot_auto_end_of_interrupt_q) begin
            prio_low_q <= p_pick[2:0];
          end
        end else begin
          isr_q[p_pick[2:0]] <= 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Checks
  property p_init_start;
    @(posedge clk) disable iff (reset)
    init_wr |=> step_q == ST_W2;
  endproperty
  a_init_start: assert property (p_init_start)
    else $error("init word one did not start sequence");

  property p_init_clear;
    @(posedge clk) disable iff (reset)
    init_wr |=> imr_q == 8'h00 && prio_low_q == `CDP_LOW_PRIO_INIT &&
                slave_addr_q == `CDP_SLAVE_INIT && !smm_q && !read_isr_q && !rot_auto_end_of_interrupt_q;
  endproperty
  a_init_clear: assert property (p_init_clear)
    else $error("init side effects missing");

  property p_seq;
    @(posedge clk) disable iff (reset)
    step_q == ST_W2 && wr_data && !init_wr |=> step_q == ST_W3 &&
      vec_base_q == $past(wdata[`CDP_VEC_HI:`CDP_VEC_LO]);
  endproperty
  a_seq: assert property (p_seq)
    else $error("word two not taken");

  property p_mask_block;
    @(posedge clk) disable iff (reset)
    1'b1 |=> (irr_q & ~$past(irr_q) & $past(imr_q)) == 8'h00;
  endproperty
  a_mask_block: assert property (p_mask_block)
    else $error("masked line set request bit");

  property p_sel_keep;
    @(posedge clk) disable iff (reset)
    status_select_command_wr && !wdata[`CDP_RR_BIT] |=> read_isr_q == $past(read_isr_q);
  endproperty
  a_sel_keep: assert property (p_sel_keep)
    else $error("status select changed without bit 1");

  property p_auto_end_of_interrupt;
    @(posedge clk) disable iff (reset)
    granted && mode_q[`CDP_MODE_AUTO_END_OF_INTERRUPT] && !eoi_rotate_command_wr && !init_wr |=> isr_q == $past(isr_q);
  endproperty
  a_auto_end_of_interrupt: assert property (p_auto_end_of_interrupt)
    else $error("auto end still set in-service bit");

  property p_ack_isr;
    @(posedge clk) disable iff (reset)
    granted && !mode_q[`CDP_MODE_AUTO_END_OF_INTERRUPT] && !init_wr |=> isr_q[$past(p_pick[2:0])];
  endproperty
  a_ack_isr: assert property (p_ack_isr)
    else $error("acknowledge did not set in-service bit");

  property p_seoi;
    @(posedge clk) disable iff (reset)
    eoi_rotate_command_wr && op_code == `CDP_OP_SEOI && !granted |=> !isr_q[$past(op_lvl)];
  endproperty
  a_seoi: assert property (p_seoi)
    else $error("specific end did not clear level");

  property p_fixed_edge;
    @(posedge clk) disable iff (reset)
    wr_elcr |=> (elcr_q & ~ELCR_MASK) == 8'h00;
  endproperty
  a_fixed_edge: assert property (p_fixed_edge)
    else $error("fixed edge input made level");
endmodule // cdpic_ctrl

// ==========================================================
// Top: port decode, cascade and acknowledge
module cdpic_top (
  input  wire logic                clk,
  input  wire logic                reset,
  input  wire cdpic_pkg::cdpic_io_t io_req,
  input  wire logic                inta,
  input  wire logic [15:0]         irq_in,
  output logic [7:0]               io_rdata_q,
  output logic                     interrupt_output_q,
  output cdpic_pkg::cdpic_ack_t    ack_q
);
  import cdpic_pkg::*;

  logic       m_int;
  logic       m_found;
  logic [2:0] m_lvl;
  logic [4:0] m_base;
  logic [7:0] m_imr;
  logic [7:0] m_elcr;
  logic [7:0] m_status;
  logic       s_int;
  logic       s_found;
  logic [2:0] s_lvl;
  logic [4:0] s_base;
  logic [7:0] s_imr;
  logic [7:0] s_elcr;
  logic [7:0] s_status;
  logic       s_ack;
  logic       cascade;
  logic [7:0] m_irq;

  assign m_irq   = {irq_in[7:3], s_int, irq_in[1:0]};
  assign cascade = m_found && m_lvl == `CDP_CASCADE_LINE;
  assign s_ack   = inta && cascade;

  cdpic_ctrl #(.ELCR_MASK(`CDP_ELCR_MASK_M)) u_master (
    .clk        (clk),
    .reset      (reset),
    .wr_base    (io_req.wr && io_req.addr == `CDP_MASTER_BASE),
    .wr_data    (io_req.wr && io_req.addr == `CDP_MASTER_DATA),
    .wr_elcr    (io_req.wr && io_req.addr == `CDP_ELCR_MASTER),
    .wdata      (io_req.wdata),
    .irq        (m_irq),
    .ack        (inta),
    .int_req    (m_int),
    .best_found (m_found),
    .best_lvl   (m_lvl),
    .vec_base   (m_base),
    .interrupt_mask        (m_imr),
    .elcr       (m_elcr),
    .status     (m_status)
  );

  cdpic_ctrl #(.ELCR_MASK(`CDP_ELCR_MASK_S)) u_slave (
    .clk        (clk),
    .reset      (reset),
    .wr_base    (io_req.wr && io_req.addr == `CDP_SLAVE_BASE),
    .wr_data    (io_req.wr && io_req.addr == `CDP_SLAVE_DATA),
    .wr_elcr    (io_req.wr && io_req.addr == `CDP_ELCR_SLAVE),
    .wdata      (io_req.wdata),
    .irq        (irq_in[15:8]),
    .ack        (s_ack),
    .int_req    (s_int),
    .best_found (s_found),
    .best_lvl   (s_lvl),
    .vec_base   (s_base),
    .interrupt_mask        (s_imr),
    .elcr       (s_elcr),
    .status     (s_status)
  );

  // ==========================================================
  // Register reads
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      io_rdata_q <= '0;
    end else if (io_req.rd) begin
      unique case (io_req.addr)
        `CDP_MASTER_BASE: io_rdata_q <= m_status;
        `CDP_MASTER_DATA: io_rdata_q <= m_imr;
        `CDP_SLAVE_BASE:  io_rdata_q <= s_status;
        `CDP_SLAVE_DATA:  io_rdata_q <= s_imr;
        `CDP_ELCR_MASTER: io_rdata_q <= m_elcr;
        `CDP_ELCR_SLAVE:  io_rdata_q <= s_elcr;
        default:          io_rdata_q <= '0;
      endcase
    end
  end

  // ==========================================================
  // Interrupt output and acknowledge vector
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      interrupt_output_q <= 1'b0;
      ack_q              <= '0;
    end else begin
      interrupt_output_q <= m_int;
      ack_q.valid        <= inta;
      if (inta) begin
        if (cascade) begin
          ack_q.vector <= {s_base, s_found ? s_lvl : `CDP_SPURIOUS_LVL};
        end else begin
          ack_q.vector <= {m_base, m_found ? m_lvl : `CDP_SPURIOUS_LVL};
        end
      end
    end
  end

  property p_mask_read;
    @(posedge clk) disable iff (reset)
    io_req.rd && io_req.addr == `CDP_MASTER_DATA |=> io_rdata_q == $past(m_imr);
  endproperty
  a_mask_read: assert property (p_mask_read)
    else $error("mask read mismatch");

  property p_cascade_block;
    @(posedge clk) disable iff (reset)
    inta && m_imr[`CDP_CASCADE_LINE] && !$past(inta) |-> !s_ack;
  endproperty
  a_cascade_block: assert property (p_cascade_block)
    else $error("slave acknowledged while input 2 masked");

  property p_vector;
    @(posedge clk) disable iff (reset)
    inta && m_found && !cascade |=> ack_q.valid && ack_q.vector == {$past(m_base), $past(m_lvl)};
  endproperty
  a_vector: assert property (p_vector)
    else $error("acknowledge vector wrong");
endmodule // cdpic_top

// ---- verif/cdpic_host.sv ----
// Host model: port writes, port reads and acknowledges toward the controllers
`timescale 1ns/1ps
module cdpic_host (
  input  wire logic                  clk,
  output cdpic_pkg::cdpic_io_t       io_req,
  output logic                       inta,
  input  wire logic [7:0]            io_rdata_q,
  input  wire cdpic_pkg::cdpic_ack_t ack_q
);
  import cdpic_pkg::*;
  // ==========================================================
  // Idle values
  initial begin
    io_req = '0;
    inta = 1'b0;
  end
  // ==========================================================
  // Port cycles, released lines inverted
  task automatic io_wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    io_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask
  task automatic io_rd(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    io_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    io_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1 d = io_rdata_q;
  endtask
  // ==========================================================
  // Acknowledge, then one spare cycle
  task automatic do_ack(output logic [7:0] v, output logic ok);
    @(posedge clk);
    inta <= 1'b1;
    @(posedge clk);
    inta <= 1'b0;
    #1;
    v = ack_q.vector;
    ok = ack_q.valid;
    @(posedge clk);
  endtask
  // ==========================================================
  // Four-word set-up sequence
  task automatic init_ctl(input logic [15:0] b, input logic [7:0] w1, w2, w3, w4);
    io_wr(b, w1);
    io_wr(b + 16'h0001, w2);
    io_wr(b + 16'h0001, w3);
    io_wr(b + 16'h0001, w4);
  endtask
endmodule // cdpic_host

// ---- verif/tb_top.sv ----
// Self-checking bench for the cascaded interrupt controllers
`timescale 1ns/1ps
module tb_top;
  import cdpic_pkg::*;
  logic        clk;
  logic        reset;
  cdpic_io_t   io_req;
  logic        inta;
  logic [15:0] irq_in;
  logic [7:0]  io_rdata_q;
  logic        interrupt_output_q;
  cdpic_ack_t  ack_q;
  logic [7:0]  rd_v;
  logic        ok_v;
  int          err_count;
  int          cmp_count;
  // ==========================================================
  // Clock and instances
  initial clk = 1'b0;
  always #2.5 clk = ~clk;
  cdpic_top i_dut (.clk(clk), .reset(reset), .io_req(io_req), .inta(inta), .irq_in(irq_in),
    .io_rdata_q(io_rdata_q), .interrupt_output_q(interrupt_output_q), .ack_q(ack_q));
  cdpic_host i_host (.clk(clk), .io_req(io_req), .inta(inta), .io_rdata_q(io_rdata_q),
    .ack_q(ack_q));
  // ==========================================================
  // Checking helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
    i_host.io_rd(a, rd_v);
    check(rd_v, exp);
  endtask
  task automatic ack_chk(input logic [7:0] exp);
    i_host.do_ack(rd_v, ok_v);
    check({7'h00, ok_v}, 8'h01);
    check(rd_v, exp);
  endtask
  task automatic pulse(input int n);
    @(posedge clk);
    irq_in[n] <= 1'b1;
    repeat (2) @(posedge clk);
    irq_in[n] <= 1'b0;
  endtask
  task automatic wait_int();
    int i;
    for (i = 0; i < 20 && interrupt_output_q !== 1'b1; i++) @(posedge clk);
    if (interrupt_output_q !== 1'b1) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, interrupt_output_q, 1'b1);
      give_verdict();
    end
  endtask
  // ==========================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    irq_in = '0;
    err_count = 0;
    cmp_count = 0;
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    rd_chk(16'h0021, 8'h00);
    i_host.io_wr(16'h0021, 8'h5a);
    rd_chk(16'h0021, 8'h5a);
    rd_chk(16'h0022, 8'h00);
    $display("test mask access done");
    i_host.init_ctl(16'h0020, 8'h11, 8'h08, 8'h04, 8'h01);
    i_host.init_ctl(16'h00a0, 8'h11, 8'h70, 8'h02, 8'h01);
    rd_chk(16'h0021, 8'h00);
    $display("test init done");
    pulse(3);
    wait_int();
    ack_chk(8'h0b);
    i_host.io_wr(16'h0020, 8'h0b);
    rd_chk(16'h0020, 8'h08);
    i_host.io_wr(16'h0020, 8'h0a);
    rd_chk(16'h0020, 8'h00);
    i_host.io_wr(16'h0020, 8'h0b);
    i_host.io_wr(16'h0020, 8'h40);
    rd_chk(16'h0020, 8'h08);
    i_host.io_wr(16'h0020, 8'h20);
    rd_chk(16'h0020, 8'h00);
    $display("test service done");
    i_host.io_wr(16'h0021, 8'h10);
    @(posedge clk);
    irq_in[5:4] <= 2'b11;
    repeat (2) @(posedge clk);
    irq_in[5:4] <= 2'b00;
    wait_int();
    i_host.io_wr(16'h0020, 8'h0a);
    rd_chk(16'h0020, 8'h20);
    ack_chk(8'h0d);
    i_host.io_wr(16'h0020, 8'h0b);
    rd_chk(16'h0020, 8'h20);
    i_host.io_wr(16'h0020, 8'h64);
    rd_chk(16'h0020, 8'h20);
    i_host.io_wr(16'h0020, 8'h65);
    rd_chk(16'h0020, 8'h00);
    i_host.io_wr(16'h0021, 8'h00);
    $display("test masking done");
    i_host.io_wr(16'h0020, 8'hc3);
    @(posedge clk);
    irq_in <= 16'h0022;
    repeat (2) @(posedge clk);
    irq_in <= 16'h0000;
    wait_int();
    ack_chk(8'h0d);
    repeat (2) @(posedge clk);
    check({7'h00, interrupt_output_q}, 8'h00);
    i_host.io_wr(16'h0020, 8'ha0);
    pulse(4);
    wait_int();
    ack_chk(8'h09);
    i_host.io_wr(16'h0020, 8'h20);
    wait_int();
    ack_chk(8'h0c);
    i_host.io_wr(16'h0020, 8'h20);
    i_host.io_wr(16'h0020, 8'hc7);
    rd_chk(16'h0020, 8'h00);
    $display("test rotation done");
    i_host.io_wr(16'h0021, 8'h04);
    pulse(9);
    repeat (10) @(posedge clk);
    check({7'h00, interrupt_output_q}, 8'h00);
    i_host.io_wr(16'h00a1, 8'h02);
    i_host.io_wr(16'h0021, 8'h00);
    i_host.io_wr(16'h00a1, 8'h00);
    wait_int();
    ack_chk(8'h71);
    i_host.io_wr(16'h00a0, 8'h20);
    i_host.io_wr(16'h0020, 8'h20);
    $display("test cascade done");
    i_host.init_ctl(16'h0020, 8'h11, 8'h08, 8'h04, 8'h11);
    pulse(9);
    wait_int();
    ack_chk(8'h71);
    pulse(8);
    wait_int();
    ack_chk(8'h70);
    i_host.io_wr(16'h00a0, 8'h20);
    i_host.io_wr(16'h00a0, 8'h20);
    i_host.io_wr(16'h0020, 8'h20);
    $display("test special nesting done");
    i_host.io_wr(16'h04d0, 8'hff);
    rd_chk(16'h04d0, 8'hf8);
    i_host.io_wr(16'h04d0, 8'h00);
    i_host.io_wr(16'h0021, 8'h80);
    i_host.init_ctl(16'h0020, 8'h19, 8'h08, 8'h04, 8'h03);
    rd_chk(16'h0021, 8'h00);
    @(posedge clk);
    irq_in[6] <= 1'b1;
    wait_int();
    ack_chk(8'h0e);
    i_host.io_wr(16'h0020, 8'h0b);
    rd_chk(16'h0020, 8'h00);
    i_host.io_wr(16'h0020, 8'h0a);
    rd_chk(16'h0020, 8'h00);
    i_host.io_wr(16'h04d0, 8'h40);
    rd_chk(16'h0020, 8'h40);
    @(posedge clk);
    irq_in[6] <= 1'b0;
    rd_chk(16'h0020, 8'h00);
    $display("test auto end done");
    give_verdict();
  end
endmodule // tb_top
